// >>> verification/tb_literal_and_return_exec.sv
// Self-checking bench for the literal and return execution block
`timescale 1ns/1ps
module tb_literal_and_return_exec import lit_ret_pkg::*; ;
	logic CLK = 1'b0;
	logic RST_N = 1'b0;
	logic INSTR_VALID = 1'b0;
	logic [OP_W-1:0] OP_SEL = OP_NOP;
	logic [ACC_W-1:0] LITERAL = 8'h00;
	logic PUSH_VALID = 1'b0;
	logic [PC_W-1:0] PUSH_ADDR = 13'h0000;
	logic IRQ_EN_CLEAR = 1'b0;
	logic [ACC_W-1:0] ACC;
	logic [PC_W-1:0] PC;
	logic GLOBAL_IRQ_ENABLE;
	logic BUSY;
	logic DONE;
	int mismatches = 0;
	int num_checks = 0;
	int cycles = 0;

	literal_and_return_exec u_dut (.CLK(CLK), .RST_N(RST_N),
		.INSTR_VALID(INSTR_VALID), .OP_SEL(OP_SEL), .LITERAL(LITERAL),
		.PUSH_VALID(PUSH_VALID), .PUSH_ADDR(PUSH_ADDR),
		.IRQ_EN_CLEAR(IRQ_EN_CLEAR), .ACC(ACC), .PC(PC),
		.GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .BUSY(BUSY), .DONE(DONE));

	always #2 CLK = ~CLK;

	task automatic finish_test();
		if (mismatches == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// The whole run needs well under 200 cycles
	always @(posedge CLK) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			mismatches++;
			finish_test();
		end
	end

	task automatic check(input string name, input logic [15:0] exp,
		input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic push(input logic [PC_W-1:0] addr);
		@(posedge CLK);
		PUSH_VALID <= 1'b1;
		PUSH_ADDR <= addr;
		@(posedge CLK);
		PUSH_VALID <= 1'b0;
	endtask

	// A return also sees a move-literal offered in its busy cycle,
	// which must be dropped, not queued
	task automatic issue(input logic [OP_W-1:0] op,
		input logic [ACC_W-1:0] lit, input bit ret);
		@(posedge CLK);
		INSTR_VALID <= 1'b1;
		OP_SEL <= op;
		// The operand port carries no don't-care bits to zero
		LITERAL <= lit;
		@(posedge CLK);
		if (ret) begin
			OP_SEL <= OP_MOVE_LIT;
			LITERAL <= 8'h33;
			#1;
			check("BUSY", 16'h1, BUSY);
			check("DONE early", 16'h0, DONE);
			@(posedge CLK);
		end
		INSTR_VALID <= 1'b0;
		#1;
		check("DONE", 16'h1, DONE);
	endtask

	task automatic t_move_nop();
		issue(OP_MOVE_LIT, 8'h5a, 0);
		check("ACC", 16'h5a, ACC);
		check("PC", 16'h1, PC);
		issue(OP_MOVE_LIT, 8'hff, 0);
		check("ACC", 16'hff, ACC);
		issue(OP_NOP, 8'h00, 0);
		issue(3'h5, 8'h11, 0);
		check("ACC", 16'hff, ACC);
		check("PC", 16'h4, PC);
	endtask

	task automatic t_ret_lit();
		push(13'h0123);
		push(13'h1abc);
		push(13'h0f0f);
		issue(OP_RET_LIT, 8'ha5, 1);
		check("PC", 16'h0f0f, PC);
		check("ACC", 16'ha5, ACC);
		check("IRQ_EN", 16'h0, GLOBAL_IRQ_ENABLE);
	endtask

	task automatic t_ret_int();
		issue(OP_RET_INT, 8'h77, 1);
		check("PC", 16'h1abc, PC);
		check("ACC", 16'ha5, ACC);
		check("IRQ_EN", 16'h1, GLOBAL_IRQ_ENABLE);
		@(posedge CLK);
		IRQ_EN_CLEAR <= 1'b1;
		@(posedge CLK);
		IRQ_EN_CLEAR <= 1'b0;
		#1;
		check("IRQ_EN clear", 16'h0, GLOBAL_IRQ_ENABLE);
	endtask

	task automatic t_ret_sub();
		issue(OP_RET_SUB, 8'h99, 1);
		check("PC", 16'h0123, PC);
		check("ACC", 16'ha5, ACC);
	endtask

	task automatic check_reset();
		check("ACC reset", 16'h0, ACC);
		check("PC reset", 16'h0, PC);
		check("IRQ_EN reset", 16'h0, GLOBAL_IRQ_ENABLE);
		check("BUSY reset", 16'h0, BUSY);
		check("DONE reset", 16'h0, DONE);
	endtask

	// Clear and re-enable meet on one edge; a push offered with the
	// return is dropped, one in the busy cycle is kept
	task automatic t_irq_race();
		push(13'h0456);
		@(posedge CLK);
		INSTR_VALID <= 1'b1;
		OP_SEL <= OP_RET_INT;
		PUSH_VALID <= 1'b1;
		PUSH_ADDR <= 13'h1111;
		@(posedge CLK);
		INSTR_VALID <= 1'b0;
		PUSH_ADDR <= 13'h0789;
		IRQ_EN_CLEAR <= 1'b1;
		@(posedge CLK);
		PUSH_VALID <= 1'b0;
		IRQ_EN_CLEAR <= 1'b0;
		#1;
		check("IRQ_EN race", 16'h1, GLOBAL_IRQ_ENABLE);
		check("PC", 16'h0456, PC);
		check("DONE", 16'h1, DONE);
		issue(OP_RET_SUB, 8'h00, 1);
		check("PC", 16'h0789, PC);
	endtask

	// A reset in mid-run restores every output, then work resumes
	task automatic t_reset_mid();
		@(posedge CLK);
		RST_N <= 1'b0;
		repeat (2) @(posedge CLK);
		RST_N <= 1'b1;
		#1;
		check_reset();
		issue(OP_MOVE_LIT, 8'h3c, 0);
		check("ACC", 16'h3c, ACC);
		check("PC", 16'h1, PC);
	endtask

	initial begin
		repeat (10) @(posedge CLK);
		RST_N <= 1'b1;
		#1;
		check_reset();
		t_move_nop();
		t_ret_lit();
		t_ret_int();
		t_ret_sub();
		t_irq_race();
		t_reset_mid();
		finish_test();
	end
endmodule

// >>> verilog/lit_ret_pkg.sv
// Shared constants and types for the literal and return execution block
package lit_ret_pkg;
	localparam int ACC_W = 8;
	localparam int PC_W = 13;
	localparam int OP_W = 3;
	localparam int STACK_DEPTH = 8;
	localparam int SP_W = 3;

	// Operation select codes driven by the decode stage
	localparam logic [OP_W-1:0] OP_NOP = 3'h0;
	localparam logic [OP_W-1:0] OP_MOVE_LIT = 3'h1;
	localparam logic [OP_W-1:0] OP_RET_INT = 3'h2;
	localparam logic [OP_W-1:0] OP_RET_LIT = 3'h3;
	localparam logic [OP_W-1:0] OP_RET_SUB = 3'h4;

	localparam logic [ACC_W-1:0] ACC_RST = 8'h00;
	localparam logic [PC_W-1:0] PC_RST = 13'h0000;
	localparam logic [PC_W-1:0] PC_STEP = 13'h0001;
	localparam logic [SP_W-1:0] SP_RST = 3'h0;
	localparam logic [SP_W-1:0] SP_STEP = 3'h1;
	localparam logic IRQ_EN_RST = 1'b0;

	// Execution is single-cycle except for the pop-and-load returns
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_POP = 2'b10
	} exec_state_t;
endpackage

// >>> verilog/literal_and_return_exec.sv
// Execution of move-literal, no-op and the three return operations
// How it works
// (RULE_01) Move-literal loads literal into accumulator, one cycle
// (RULE_02) Decoder zeroes the unused move-literal bits
// (RULE_03) Interrupt return pops stack into PC, two cycles
// (RULE_04) Interrupt return sets the global interrupt enable
// (RULE_05) Literal return loads literal into accumulator
// (RULE_06) Literal return pops stack into PC, two cycles
// (RULE_07) Subroutine return pops into PC, accumulator kept
// (RULE_08) No-op advances PC, changes nothing else
`timescale 1ns/1ps
module literal_and_return_exec
	import lit_ret_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic INSTR_VALID,
	input wire logic [OP_W-1:0] OP_SEL,
	input wire logic [ACC_W-1:0] LITERAL,
	input wire logic PUSH_VALID,
	input wire logic [PC_W-1:0] PUSH_ADDR,
	input wire logic IRQ_EN_CLEAR,
	output logic [ACC_W-1:0] ACC,
	output logic [PC_W-1:0] PC,
	output logic GLOBAL_IRQ_ENABLE,
	output logic BUSY,
	output logic DONE
);
	exec_state_t state_q, state_d;
	logic [ACC_W-1:0] acc_q, acc_d;
	logic [PC_W-1:0] pc_q, pc_d;
	logic [SP_W-1:0] sp_q, sp_d;
	logic [OP_W-1:0] op_q, op_d;
	logic [ACC_W-1:0] lit_q, lit_d;
	logic irq_en_q, irq_en_d;
	logic busy_q, busy_d;
	logic done_q, done_d;
	logic accept;
	logic is_return;
	logic push_en;
	logic [SP_W-1:0] pop_addr;
	logic [PC_W-1:0] stack_top;

	assign accept = INSTR_VALID && state_q == ST_IDLE;
	assign is_return = OP_SEL == OP_RET_INT || OP_SEL == OP_RET_LIT ||
		OP_SEL == OP_RET_SUB;
	// A push loses to a return taken in the same cycle, so the pointer
	// never moves both ways at once.
	assign push_en = PUSH_VALID && !(accept && is_return);
	assign pop_addr = sp_q - SP_STEP;

	return_stack_mem u_stack (
		.clk(CLK),
		.wr_en(push_en),
		.wr_addr(sp_q),
		.wr_data(PUSH_ADDR),
		.rd_addr(pop_addr),
		.rd_data(stack_top)
	);

	always_comb begin
		state_d = state_q;
		acc_d = acc_q;
		pc_d = pc_q;
		sp_d = sp_q;
		op_d = op_q;
		lit_d = lit_q;
		irq_en_d = irq_en_q;
		busy_d = 1'b0;
		done_d = 1'b0;
		if (IRQ_EN_CLEAR) begin
			irq_en_d = 1'b0;
		end
		if (push_en) begin
			sp_d = sp_q + SP_STEP;
		end
		unique case (state_q)
			ST_IDLE: begin
				if (accept) begin
					if (is_return) begin
						// Stack read is registered: PC loads next cycle
						sp_d = pop_addr; // [RULE_03] [RULE_06] [RULE_07]
						op_d = OP_SEL;
						lit_d = LITERAL;
						busy_d = 1'b1;
						state_d = ST_POP;
					end else begin
						if (OP_SEL == OP_MOVE_LIT) begin
							// Upper word bits are zero from decode
							acc_d = LITERAL; // [RULE_01]
						end
						// Unknown codes behave as a no-op
						pc_d = pc_q + PC_STEP; // [RULE_08]
						done_d = 1'b1;
					end
				end
			end
			ST_POP: begin
				pc_d = stack_top; // [RULE_03] [RULE_06] [RULE_07]
				if (op_q == OP_RET_LIT) begin
					acc_d = lit_q; // [RULE_05]
				end
				if (op_q == OP_RET_INT) begin
					// Re-enable wins over a simultaneous clear
					irq_en_d = 1'b1; // [RULE_04]
				end
				done_d = 1'b1;
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			state_q <= ST_IDLE;
			acc_q <= ACC_RST;
			pc_q <= PC_RST;
			sp_q <= SP_RST;
			op_q <= OP_NOP;
			lit_q <= ACC_RST;
			irq_en_q <= IRQ_EN_RST;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			state_q <= state_d;
			acc_q <= acc_d;
			pc_q <= pc_d;
			sp_q <= sp_d;
			op_q <= op_d;
			lit_q <= lit_d;
			irq_en_q <= irq_en_d;
			busy_q <= busy_d;
			done_q <= done_d;
		end
	end

	assign ACC = acc_q;
	assign PC = pc_q;
	assign GLOBAL_IRQ_ENABLE = irq_en_q;
	assign BUSY = busy_q;
	assign DONE = done_q;

	a_move_lit_load: assert property ( // [RULE_01]
		@(posedge CLK) disable iff (!RST_N)
		accept && OP_SEL == OP_MOVE_LIT |=>
		acc_q == $past(LITERAL) && pc_q == $past(pc_q) + PC_STEP && done_q)
		else $error("move literal did not load accumulator in one cycle");

	a_move_sp_keep: assert property ( // [RULE_01]
		@(posedge CLK) disable iff (!RST_N)
		accept && OP_SEL == OP_MOVE_LIT && !PUSH_VALID |=>
		sp_q == $past(sp_q))
		else $error("move literal disturbed the return stack");

	a_ret_int_pc: assert property ( // [RULE_03]
		@(posedge CLK) disable iff (!RST_N)
		accept && OP_SEL == OP_RET_INT |=> busy_q && !done_q
		##1 done_q && !busy_q && pc_q == $past(stack_top))
		else $error("interrupt return did not load PC in two cycles");

	a_ret_int_irq: assert property ( // [RULE_04]
		@(posedge CLK) disable iff (!RST_N)
		accept && OP_SEL == OP_RET_INT |-> ##2 irq_en_q)
		else $error("interrupt return left interrupts disabled");

	a_irq_set_wins: assert property ( // [RULE_04]
		@(posedge CLK) disable iff (!RST_N)
		state_q == ST_POP && op_q == OP_RET_INT && IRQ_EN_CLEAR |=> irq_en_q)
		else $error("clear beat the interrupt return re-enable");

	a_irq_clear_takes: assert property (@(posedge CLK) disable iff (!RST_N)
		IRQ_EN_CLEAR && !(state_q == ST_POP && op_q == OP_RET_INT) |=>
		!irq_en_q)
		else $error("interrupt enable clear was lost");

	a_irq_hold: assert property (@(posedge CLK) disable iff (!RST_N)
		!IRQ_EN_CLEAR && !(state_q == ST_POP && op_q == OP_RET_INT) |=>
		irq_en_q == $past(irq_en_q))
		else $error("interrupt enable changed without cause");

	a_ret_lit_acc: assert property ( // [RULE_05]
		@(posedge CLK) disable iff (!RST_N)
		accept && OP_SEL == OP_RET_LIT |->
		##2 acc_q == $past(LITERAL, 2))
		else $error("literal return loaded wrong accumulator value");

	a_ret_lit_pop: assert property ( // [RULE_06]
		@(posedge CLK) disable iff (!RST_N)
		accept && OP_SEL == OP_RET_LIT |=>
		sp_q == $past(sp_q) - SP_STEP ##1 done_q && pc_q == $past(stack_top))
		else $error("literal return did not pop into PC");

	a_ret_sub_keep: assert property ( // [RULE_07]
		@(posedge CLK) disable iff (!RST_N)
		accept && OP_SEL == OP_RET_SUB |->
		##2 done_q && acc_q == $past(acc_q, 2) && pc_q == $past(stack_top))
		else $error("subroutine return changed accumulator or missed PC");

	a_ret_pop_sp: assert property ( // [RULE_03] [RULE_07]
		@(posedge CLK) disable iff (!RST_N)
		accept && is_return |=> sp_q == $past(sp_q) - SP_STEP)
		else $error("return did not pop exactly one stack entry");

	a_push_step_sp: assert property (@(posedge CLK) disable iff (!RST_N)
		PUSH_VALID && !(accept && is_return) |=>
		sp_q == $past(sp_q) + SP_STEP)
		else $error("push did not advance the stack pointer");

	a_nop_quiet: assert property ( // [RULE_08]
		@(posedge CLK) disable iff (!RST_N)
		accept && OP_SEL == OP_NOP && !PUSH_VALID && !IRQ_EN_CLEAR |=>
		acc_q == $past(acc_q) && sp_q == $past(sp_q) &&
		irq_en_q == $past(irq_en_q) && pc_q == $past(pc_q) + PC_STEP)
		else $error("no-op changed state");

	a_other_ops_quiet: assert property ( // [RULE_08]
		@(posedge CLK) disable iff (!RST_N)
		accept && !is_return && OP_SEL != OP_MOVE_LIT |=> done_q &&
		acc_q == $past(acc_q) && pc_q == $past(pc_q) + PC_STEP)
		else $error("unused code did not act as a no-op");

	a_pop_busy_once: assert property ( // [RULE_03]
		@(posedge CLK) disable iff (!RST_N)
		busy_q |=> !busy_q && done_q)
		else $error("return held busy longer than one extra cycle");

	a_busy_no_done: assert property ( // [RULE_03]
		@(posedge CLK) disable iff (!RST_N)
		busy_q |-> !done_q)
		else $error("return signalled done in its busy cycle");

	// No disable here: this one watches the reset itself
	a_reset_values: assert property (@(posedge CLK)
		!RST_N |=> acc_q == ACC_RST && pc_q == PC_RST && sp_q == SP_RST &&
		irq_en_q == IRQ_EN_RST && !busy_q && !done_q)
		else $error("reset left state at non-reset values");
endmodule

// >>> verilog/return_stack_mem.sv
// Hardware return stack storage with a registered read port
`timescale 1ns/1ps
module return_stack_mem
	import lit_ret_pkg::*;
(
	input wire logic clk,
	input wire logic wr_en,
	input wire logic [SP_W-1:0] wr_addr,
	input wire logic [PC_W-1:0] wr_data,
	input wire logic [SP_W-1:0] rd_addr,
	output logic [PC_W-1:0] rd_data
);
	logic [PC_W-1:0] mem_q [STACK_DEPTH];

	// Entries carry no reset; software never sees an unwritten slot
	// unless it returns more often than it called.
	for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_entry
		always_ff @(posedge clk) begin
			if (wr_en && wr_addr == SP_W'(i)) begin
				mem_q[i] <= wr_data;
			end
		end
	end

	always_ff @(posedge clk) begin
		rd_data <= mem_q[rd_addr];
	end
endmodule
